// ### rtl/tcls_defines.svh
`ifndef TCLS_DEFINES_SVH
`define TCLS_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TCLS_ADDR_CTRL 5'h00
`define TCLS_ADDR_CMD 5'h04
`define TCLS_ADDR_COUNT 5'h08
`define TCLS_ADDR_SNAP 5'h0C
`define TCLS_ADDR_ITEM_CNT 5'h10
`define TCLS_ADDR_ITEM_SNAP 5'h14

// ----------------------------------------
// Control and command register fields
// ----------------------------------------
`define TCLS_CTRL_MODE_BIT 0
`define TCLS_CTRL_CNT_ON_BIT 1
`define TCLS_CTRL_SNAP_ON_BIT 2
`define TCLS_CTRL_FREE_RUN_BIT 3
`define TCLS_CTRL_CLR_LSB 4
`define TCLS_CTRL_CLR_MSB 5
`define TCLS_CMD_CLEAR_BIT 0

// ----------------------------------------
// Widths, count step and limit, and reset values
// ----------------------------------------
`define TCLS_WORD_W 32
`define TCLS_COUNT_RST 32'h0000_0000
`define TCLS_COUNT_STEP 32'h0000_0001
`define TCLS_COUNT_MAX 32'hFFFF_FFFF
`define TCLS_WORD_ZERO 32'h0000_0000

`endif

// ### rtl/tcls_pkg.sv
package tcls_pkg;

	// Clear origin of the trigger count, off first so reset lands on it
	typedef enum logic [1:0] {
		CLR_OFF,
		CLR_LINE_ONE,
		CLR_LINE_TWO,
		CLR_SOFTWARE
	} count_clear_origin_t;

endpackage

// ### rtl/trigger_counter_line_snapshot.sv
`timescale 1ns/100ps
// Behaviour
// - The trigger count is an unsigned 32-bit register.
// - The first trigger after start gives 1 and each later trigger adds one.
// - After 4294967295 the next trigger gives 0 and counting goes on upward.
// - In free-running mode without triggers the count item is not provided.
// - Item enables act only while appended-data mode is on; mode off disables all items.
// - An enabled count item carries the count of the trigger that started the image.
// - Every external trigger increments the count, even one that starts no image.
// - Power-up reset returns the trigger count to 0.
// - The clear origin is input line one, input line two, software or off.
// - After reset the clear origin is off, so clearing is disabled.
// - With the software origin the count clears only on the software clear command.
// - Each trigger samples all line levels; an enabled snapshot item attaches that sample.
// - The line snapshot is a 32-bit word with fixed bit positions per line.
// - A snapshot bit is 0 for a low line and 1 for a high line at the trigger.
`include "tcls_defines.svh"

module trigger_counter_line_snapshot #(
	parameter int IN_LINES = 2,
	parameter int OUT_LINES = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trigger_pin,
	input wire logic [IN_LINES-1:0] in_lines,
	input wire logic [OUT_LINES-1:0] out_lines,
	input wire logic image_start,
	output logic [31:0] item_count,
	output logic item_count_valid,
	output logic [31:0] item_snapshot,
	output logic item_snapshot_valid
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (IN_LINES < 2 || OUT_LINES < 1 || IN_LINES + OUT_LINES > `TCLS_WORD_W) begin : g_bad
		$error("line counts do not fit the snapshot word");
	end

	localparam int SNAP_USED = IN_LINES + OUT_LINES;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [IN_LINES:0] pin_meta_r;
	logic [IN_LINES:0] pin_sync_r;
	logic [IN_LINES:0] pin_prev_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {trigger_pin, in_lines};
			pin_sync_r <= pin_meta_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_prev_r <= '0;
		end else begin
			pin_prev_r <= pin_sync_r;
		end
	end

	logic acquisition_trigger_event;
	logic input_line_one;
	logic input_line_two;
	logic line_one_rise;
	logic line_two_rise;
	assign acquisition_trigger_event = pin_sync_r[IN_LINES] & ~pin_prev_r[IN_LINES];
	assign input_line_one = pin_sync_r[0];
	assign input_line_two = pin_sync_r[1];
	assign line_one_rise = input_line_one & ~pin_prev_r[0];
	assign line_two_rise = input_line_two & ~pin_prev_r[1];

	logic [IN_LINES-1:0] line_lvls;
	assign line_lvls = pin_sync_r[IN_LINES-1:0];

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	// One wait cycle keeps read data registered
	logic ack_r;
	logic bus_req;
	logic wr_fire;
	logic rd_fire;
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_r;
	assign wr_fire = avs_write & ack_r;
	assign rd_fire = avs_read & ~ack_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req & ~ack_r;
		end
	end

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
		hit = addr == target;
	endfunction

	logic appended_data_mode_on_r;
	logic count_item_on_r;
	logic snap_item_on_r;
	logic free_run_r;
	tcls_pkg::count_clear_origin_t count_clear_origin_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			appended_data_mode_on_r <= 1'b0;
			count_item_on_r <= 1'b0;
			snap_item_on_r <= 1'b0;
			free_run_r <= 1'b0;
			count_clear_origin_r <= tcls_pkg::CLR_OFF;
		end else if (wr_fire && hit(avs_address, `TCLS_ADDR_CTRL) && avs_byteenable[0]) begin
			appended_data_mode_on_r <= avs_writedata[`TCLS_CTRL_MODE_BIT];
			count_item_on_r <= avs_writedata[`TCLS_CTRL_CNT_ON_BIT];
			snap_item_on_r <= avs_writedata[`TCLS_CTRL_SNAP_ON_BIT];
			free_run_r <= avs_writedata[`TCLS_CTRL_FREE_RUN_BIT];
			count_clear_origin_r <= tcls_pkg::count_clear_origin_t'(
				avs_writedata[`TCLS_CTRL_CLR_MSB:`TCLS_CTRL_CLR_LSB]);
		end
	end

	logic count_clear_command;
	assign count_clear_command = wr_fire && hit(avs_address, `TCLS_ADDR_CMD)
		&& avs_byteenable[0] && avs_writedata[`TCLS_CMD_CLEAR_BIT];

	// ----------------------------------------
	// Trigger count
	// ----------------------------------------
	logic [31:0] trig_count_r;
	logic [31:0] trig_count_nxt;
	logic count_clear;

	always_comb begin
		case (count_clear_origin_r)
			tcls_pkg::CLR_LINE_ONE: count_clear = line_one_rise;
			tcls_pkg::CLR_LINE_TWO: count_clear = line_two_rise;
			tcls_pkg::CLR_SOFTWARE: count_clear = count_clear_command;
			default: count_clear = 1'b0;
		endcase
	end

	// A trigger in the clearing cycle still counts, so it is not lost
	always_comb begin
		trig_count_nxt = count_clear ? `TCLS_COUNT_RST : trig_count_r;
		if (acquisition_trigger_event) begin
			trig_count_nxt = trig_count_nxt + `TCLS_COUNT_STEP;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			trig_count_r <= `TCLS_COUNT_RST;
		end else begin
			trig_count_r <= trig_count_nxt;
		end
	end

	// ----------------------------------------
	// Line snapshot
	// ----------------------------------------
	logic [31:0] all_lines_snapshot_r;
	logic [31:0] snap_word;
	logic [31:0] trig_latch_r;
	logic trig_seen_r;

	always_comb begin
		snap_word = `TCLS_WORD_ZERO;
		snap_word[SNAP_USED-1:0] = {out_lines, line_lvls};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			all_lines_snapshot_r <= `TCLS_WORD_ZERO;
			trig_latch_r <= `TCLS_COUNT_RST;
			trig_seen_r <= 1'b0;
		end else if (acquisition_trigger_event) begin
			all_lines_snapshot_r <= snap_word;
			trig_latch_r <= trig_count_nxt;
			trig_seen_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Appended items
	// ----------------------------------------
	logic cnt_attach;
	logic snap_attach;
	// Free run has no trigger, so no count value belongs to the image
	assign cnt_attach = image_start & appended_data_mode_on_r & count_item_on_r
		& ~free_run_r & trig_seen_r;
	assign snap_attach = image_start & appended_data_mode_on_r & snap_item_on_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			item_count <= `TCLS_WORD_ZERO;
			item_count_valid <= 1'b0;
		end else begin
			item_count_valid <= cnt_attach;
			if (cnt_attach) begin
				item_count <= trig_latch_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			item_snapshot <= `TCLS_WORD_ZERO;
			item_snapshot_valid <= 1'b0;
		end else begin
			item_snapshot_valid <= snap_attach;
			if (snap_attach) begin
				item_snapshot <= all_lines_snapshot_r;
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [31:0] rd_word;
	always_comb begin
		rd_word = `TCLS_WORD_ZERO;
		case (avs_address)
			`TCLS_ADDR_CTRL: begin
				rd_word[`TCLS_CTRL_MODE_BIT] = appended_data_mode_on_r;
				rd_word[`TCLS_CTRL_CNT_ON_BIT] = count_item_on_r;
				rd_word[`TCLS_CTRL_SNAP_ON_BIT] = snap_item_on_r;
				rd_word[`TCLS_CTRL_FREE_RUN_BIT] = free_run_r;
				rd_word[`TCLS_CTRL_CLR_MSB:`TCLS_CTRL_CLR_LSB] = count_clear_origin_r;
			end
			`TCLS_ADDR_COUNT: rd_word = trig_count_r;
			`TCLS_ADDR_SNAP: rd_word = all_lines_snapshot_r;
			`TCLS_ADDR_ITEM_CNT: rd_word = item_count;
			`TCLS_ADDR_ITEM_SNAP: rd_word = item_snapshot;
			default: rd_word = `TCLS_WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= `TCLS_WORD_ZERO;
		end else if (rd_fire) begin
			avs_readdata <= rd_word;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence trig_no_clear;
		acquisition_trigger_event && !count_clear;
	endsequence

	sequence clear_event;
		count_clear;
	endsequence

	chk_count_step: assert property (trig_no_clear |=>
		trig_count_r == $past(trig_count_r) + `TCLS_COUNT_STEP)
		else $error("count did not step by one");

	chk_count_wrap: assert property (trig_no_clear and trig_count_r == `TCLS_COUNT_MAX
		|=> trig_count_r == `TCLS_COUNT_RST)
		else $error("count did not wrap to zero");

	chk_count_hold: assert property (!acquisition_trigger_event && !count_clear
		|=> $stable(trig_count_r))
		else $error("count moved without a trigger");

	chk_clear_value: assert property (clear_event ##0 !acquisition_trigger_event
		|=> trig_count_r == `TCLS_COUNT_RST)
		else $error("clear did not zero the count");

	chk_off_no_clear: assert property (count_clear_origin_r == tcls_pkg::CLR_OFF
		|-> !count_clear)
		else $error("clear while origin off");

	chk_soft_clear: assert property (count_clear_origin_r == tcls_pkg::CLR_SOFTWARE
		&& count_clear |-> count_clear_command)
		else $error("software clear without command");

	chk_mode_gate: assert property (!appended_data_mode_on_r
		|=> !item_count_valid && !item_snapshot_valid)
		else $error("item attached with mode off");

	chk_free_run: assert property (free_run_r |=> !item_count_valid)
		else $error("count item in free run");

	chk_item_count: assert property (cnt_attach |=> item_count == $past(trig_latch_r))
		else $error("wrong count attached");

	chk_snap_sample: assert property (acquisition_trigger_event
		|=> all_lines_snapshot_r[SNAP_USED-1:0] == {$past(out_lines), $past(line_lvls)})
		else $error("snapshot missed the lines");

	chk_snap_zero: assert property (all_lines_snapshot_r >> SNAP_USED == `TCLS_WORD_ZERO)
		else $error("unused snapshot bits set");

	chk_bus_ack: assert property (bus_req && !ack_r |=> !avs_waitrequest || !bus_req)
		else $error("bus answer late");

endmodule // trigger_counter_line_snapshot

// ### tb/test_trigger_counter_line_snapshot.sv
`timescale 1ns/100ps
`include "tcls_defines.svh"
`define CHK(g,e) begin total_checks++; if ((g) !== (e)) begin failures++; \
$display("ERROR %0t: got %h want %h", $time, g, e); end end
module test_trigger_counter_line_snapshot;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, trigger_pin, image_start, fire;
	logic item_count_valid, item_snapshot_valid;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, item_count, item_snapshot, exp_cnt, exp_snp;
	logic [31:0] exp_w;
	logic [3:0] avs_byteenable, out_lines;
	logic [1:0] in_lines, line_lvl;
	logic [31:0] q_rd[$], q_cnt[$], q_snp[$];
	int failures, total_checks, k;
	integer seed;
	trigger_counter_line_snapshot DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trigger_pin(trigger_pin), .in_lines(in_lines),
		.out_lines(out_lines), .image_start(image_start), .item_count(item_count),
		.item_count_valid(item_count_valid), .item_snapshot(item_snapshot),
		.item_snapshot_valid(item_snapshot_valid));
	trigger_line_source src (.clk(clk), .rst(rst), .fire(fire), .line_lvl(line_lvl),
		.trigger_pin(trigger_pin), .in_lines(in_lines));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------
	// Drivers
	// ----------------
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		// Only the watchdog ends a wait that never answers
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task setl(input logic [1:0] lv);
		line_lvl <= lv;
		repeat (6) @(posedge clk);
	endtask
	task trig(input logic [1:0] lv);
		logic [3:0] r;
		r = 4'($random(seed));
		out_lines <= r;
		exp_snp = {26'h0, r, lv};
		setl(lv);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (8) @(posedge clk);
		exp_cnt++;
	endtask
	task img(input logic c, input logic s);
		if (c)
			q_cnt.push_back(exp_cnt);
		if (s)
			q_snp.push_back(exp_snp);
		@(posedge clk);
		image_start <= 1'b1;
		@(posedge clk);
		image_start <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------
	// Monitor
	// ----------------
	always @(posedge clk) begin
		// Pop once into a holder: the macro reads its arguments twice
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			exp_w = q_rd.pop_front();
			`CHK(avs_readdata, exp_w)
		end
		if (item_count_valid === 1'b1) begin
			if (q_cnt.size() == 0)
				`CHK(1'b1, 1'b0)
			else begin
				exp_w = q_cnt.pop_front();
				`CHK(item_count, exp_w)
			end
		end
		if (item_snapshot_valid === 1'b1) begin
			if (q_snp.size() == 0)
				`CHK(1'b1, 1'b0)
			else begin
				exp_w = q_snp.pop_front();
				`CHK(item_snapshot, exp_w)
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done;
	end
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		seed = 32'hA206;
		{rst, avs_read, avs_write, image_start, fire} = 5'h10;
		{avs_address, avs_writedata, out_lines, line_lvl} = '0;
		avs_byteenable = 4'hF;
		exp_cnt = 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(`TCLS_ADDR_CTRL, 32'h0);
		rd(`TCLS_ADDR_COUNT, 32'h0);
		rd(5'h1C, 32'h0);
		img(1'b0, 1'b0);
		bus(1'b1, `TCLS_ADDR_CTRL, 32'h07);
		trig(2'($random(seed)));
		img(1'b1, 1'b1);
		trig(2'($random(seed)));
		trig(2'($random(seed)));
		trig(2'($random(seed)));
		img(1'b1, 1'b1);
		rd(`TCLS_ADDR_COUNT, exp_cnt);
		rd(`TCLS_ADDR_SNAP, exp_snp);
		bus(1'b1, `TCLS_ADDR_CMD, 32'h1);
		rd(`TCLS_ADDR_COUNT, exp_cnt);
		bus(1'b1, `TCLS_ADDR_CTRL, 32'h37);
		bus(1'b1, `TCLS_ADDR_CMD, 32'h1);
		exp_cnt = 32'h0;
		rd(`TCLS_ADDR_COUNT, 32'h0);
		rd(`TCLS_ADDR_CMD, 32'h0);
		trig(2'($random(seed)));
		img(1'b1, 1'b1);
		// Only the picked line clears; the other line rising must not
		for (k = 1; k < 3; k++) begin
			bus(1'b1, `TCLS_ADDR_CTRL, 32'h07 | (32'(k) << 4));
			trig(2'h0);
			setl(2'(3 - k));
			rd(`TCLS_ADDR_COUNT, exp_cnt);
			setl(2'h3);
			exp_cnt = 32'h0;
			rd(`TCLS_ADDR_COUNT, 32'h0);
		end
		bus(1'b1, `TCLS_ADDR_CTRL, 32'h0F);
		trig(2'($random(seed)));
		img(1'b0, 1'b1);
		bus(1'b1, `TCLS_ADDR_CTRL, 32'h06);
		img(1'b0, 1'b0);
		bus(1'b1, `TCLS_ADDR_COUNT, 32'h5A5A5A5A);
		rd(`TCLS_ADDR_COUNT, exp_cnt);
		repeat (4) @(posedge clk);
		`CHK(q_rd.size() + q_cnt.size() + q_snp.size(), 0)
		test_done;
	end
endmodule // test_trigger_counter_line_snapshot

// ### tb/trigger_line_source.sv
`timescale 1ns/100ps
module trigger_line_source (
	input wire logic clk,
	input wire logic rst,
	input wire logic fire,
	input wire logic [1:0] line_lvl,
	output logic trigger_pin,
	output logic [1:0] in_lines
);
	logic [2:0] pulse_r;
	// ----------------
	// Trigger pulse
	// ----------------
	// Two cycles high, at least three low: the synchroniser never loses an edge
	always_ff @(posedge clk) begin
		if (rst)
			pulse_r <= 3'h0;
		else if (fire && pulse_r == 3'h0)
			pulse_r <= 3'h4;
		else if (pulse_r != 3'h0)
			pulse_r <= pulse_r - 3'h1;
	end
	assign trigger_pin = (pulse_r > 3'h2);
	always_ff @(posedge clk) begin
		in_lines <= line_lvl;
	end
endmodule // trigger_line_source
